// ---- rtl/rss_sequencer.sv ----
/*
  Reset source sequencer: merges power-on, brown-out, pin and watchdog
  resets, runs the power-up delay and watchdog from the slow oscillator,
  keeps status and power-control flags, and steers the program counter.
  Assumes the detector, pin and slow oscillator inputs are asynchronous,
  configuration straps are static, and core strobes are on clk_i.
*/
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "rss_consts.svh"

module rss_sequencer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // pins and detectors
  input  wire logic        external_reset_pin_i,
  output logic             external_reset_pin_o,
  output logic             external_reset_pin_oe_b_o,
  output logic             pin_pullup_en_o,
  output logic             prog_pin_level_o,
  input  wire logic        por_detect_i,
  input  wire logic        bor_detect_i,
  input  wire logic        lf_osc_i,
  // configuration straps
  input  wire logic        pin_reset_enable_cfg_i,
  input  wire logic        powerup_delay_enable_cfg_b_i,
  input  wire logic        watchdog_enable_cfg_i,
  input  wire logic [1:0]  brownout_enable_cfg_i,
  // core side
  input  wire logic        sleep_i,
  input  wire logic        clrwdt_i,
  input  wire logic        wake_irq_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic [12:0] pc_i,
  output logic             core_rst_b_o,
  output logic             pc_load_o,
  output logic [12:0]      pc_value_o,
  output logic             push_o,
  output logic [2:0]       reset_kind_o,
  output logic [7:0]       status_o,
  output logic [7:0]       timer_zero_o,
  // register port
  input  wire logic [1:0]  addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rd_data_o
);

  localparam int FILT_LAST = `RSS_FILT_CYC - 1;

  localparam rss_pkg::rss_q_t Q_RST = '{
    st:         rss_pkg::rss_st_hold,
    kind:       rss_pkg::rss_k_por,
    pin_sy:     3'h7,
    por_sy:     3'h7,
    por_lvl:    1'b1,
    pin_filt:   1'b1,
    status:     `RSS_STATUS_POR,
    option:     `RSS_OPTION_RST,
    pin_oe_b:   1'b1,
    default:    '0
  };

  rss_pkg::rss_q_t q;
  rss_pkg::rss_q_t next_q;

  logic       lf_tick;
  logic       bor_on;
  logic       por_hold;
  logic       bor_hold;
  logic       pin_hold;
  logic       wdt_on;
  logic       wdt_base;
  logic       wdt_to;
  logic [7:0] m_wdt;
  logic [7:0] m_tmr;

  // a level is taken once the second and third stages agree
  function automatic logic agree(input logic [2:0] s);
    return s[1] == s[2];
  endfunction

  // prescaler mask for rate 1:2^(ps+extra)
  function automatic logic [7:0] ps_mask(input logic [2:0] ps, input logic extra);
    logic [8:0] one_hot;
    one_hot = 9'h001 << ({1'b0, ps} + {3'h0, extra});
    return 8'(one_hot - 9'h001);
  endfunction

  assign lf_tick  = agree(q.lf_sy) && q.lf_sy[2] && !q.lf_lvl;
  assign bor_on   = brownout_enable_cfg_i == 2'h3 ||
                    (brownout_enable_cfg_i == 2'h2 && q.st != rss_pkg::rss_st_sleep);
  assign por_hold = q.por_lvl;
  assign bor_hold = bor_on && q.bor_lvl;
  assign pin_hold = pin_reset_enable_cfg_i && !q.pin_filt;
  assign wdt_on   = watchdog_enable_cfg_i;
  assign m_wdt    = ps_mask(q.option[2:0], 1'b0);
  assign m_tmr    = ps_mask(q.option[2:0], 1'b1);
  assign wdt_base = wdt_on && lf_tick && q.wdt_cnt == 10'(`RSS_WDT_TICKS - 1);
  assign wdt_to   = wdt_base &&
                    (!q.option[`RSS_PSA_BIT] || (q.pre & m_wdt) == m_wdt);

  always_comb begin
    next_q = q;
    next_q.pin_sy = {q.pin_sy[1:0], external_reset_pin_i};
    next_q.por_sy = {q.por_sy[1:0], por_detect_i};
    next_q.bor_sy = {q.bor_sy[1:0], bor_detect_i};
    next_q.lf_sy  = {q.lf_sy[1:0], lf_osc_i};
    if (agree(q.por_sy)) begin
      next_q.por_lvl = q.por_sy[2];
    end
    if (agree(q.bor_sy)) begin
      next_q.bor_lvl = q.bor_sy[2];
    end
    if (agree(q.lf_sy)) begin
      next_q.lf_lvl = q.lf_sy[2];
    end

    // synchronised level must stand the whole filter time to count
    if (agree(q.pin_sy) && q.pin_sy[2] != q.pin_filt) begin
      if (q.filt_cnt == 5'(FILT_LAST)) begin
        next_q.pin_filt = q.pin_sy[2];
        next_q.filt_cnt = '0;
      end else begin
        next_q.filt_cnt = q.filt_cnt + 5'h1;
      end
    end else begin
      next_q.filt_cnt = '0;
    end

    next_q.pin_out    = 1'b0;
    next_q.pin_oe_b   = 1'b1;
    next_q.pullup_en  = pin_reset_enable_cfg_i;
    next_q.prog_level = q.pin_filt;
    next_q.pc_load    = 1'b0;
    next_q.push       = 1'b0;
    next_q.vec_pend   = 1'b0;
    next_q.rd_data    = 8'h00;

    // shared prescaler and timer zero
    if (q.option[`RSS_PSA_BIT]) begin
      next_q.tmr0 = q.tmr0 + 8'h01;
      if (wdt_base) begin
        next_q.pre = q.pre + 8'h01;
      end
    end else begin
      next_q.pre = q.pre + 8'h01;
      if ((q.pre & m_tmr) == m_tmr) begin
        next_q.tmr0 = q.tmr0 + 8'h01;
      end
    end
    if (wdt_on && lf_tick) begin
      next_q.wdt_cnt = wdt_base ? 10'h000 : q.wdt_cnt + 10'h001;
    end

    // software writes after the timer count, so resets and flag updates in the same cycle win but the count does not
    if (wr_i) begin
      if (addr_i == `RSS_OFF_STATUS) begin
        next_q.status = {wr_data_i[7:5], q.status[4:3], wr_data_i[2:0]};
      end else if (addr_i == `RSS_OFF_OPTION) begin
        next_q.option = wr_data_i;
      end else if (addr_i == `RSS_OFF_POWER_CONTROL_REG) begin
        next_q.power_control_reg = wr_data_i[1:0];
      end else if (addr_i == `RSS_OFF_TMR0) begin
        next_q.tmr0 = wr_data_i;
        if (!q.option[`RSS_PSA_BIT]) begin
          next_q.pre = 8'h00;
        end
      end
    end

    if (q.vec_pend) begin
      next_q.pc_load  = 1'b1;
      next_q.pc_value = `RSS_PC_VECTOR;
      next_q.push     = 1'b1;
    end

    if (por_hold) begin
      next_q.st         = rss_pkg::rss_st_hold;
      next_q.kind       = rss_pkg::rss_k_por;
      next_q.status     = `RSS_STATUS_POR;
      next_q.power_control_reg       = 2'h0;
      next_q.core_rst_b = 1'b0;
    end else if (bor_hold) begin
      next_q.st                    = rss_pkg::rss_st_hold;
      next_q.kind                  = rss_pkg::rss_k_bor;
      next_q.status                = {3'h0, 2'h3, q.status[2:0]};
      next_q.power_control_reg[`RSS_BOR_BIT]    = 1'b0;
      next_q.core_rst_b            = 1'b0;
    end else begin
      case (q.st)
        rss_pkg::rss_st_hold: begin
          next_q.core_rst_b = 1'b0;
          if (!pin_hold) begin
            if ((q.kind == rss_pkg::rss_k_por || q.kind == rss_pkg::rss_k_bor) &&
                !powerup_delay_enable_cfg_b_i) begin
              next_q.st = rss_pkg::rss_st_delay;
            end else begin
              next_q.st         = rss_pkg::rss_st_run;
              next_q.core_rst_b = 1'b1;
            end
          end
        end
        rss_pkg::rss_st_delay: begin
          next_q.core_rst_b = 1'b0;
          if (q.powerup_delay_timer_cnt == 12'(`RSS_POWERUP_DELAY_TIMER_TICKS)) begin
            if (!pin_hold) begin
              next_q.st         = rss_pkg::rss_st_run;
              next_q.core_rst_b = 1'b1;
            end
          end else if (lf_tick) begin
            next_q.powerup_delay_timer_cnt = q.powerup_delay_timer_cnt + 12'h001;
          end
        end
        rss_pkg::rss_st_run: begin
          if (pin_hold) begin
            next_q.st          = rss_pkg::rss_st_hold;
            next_q.kind        = rss_pkg::rss_k_pin_run;
            next_q.status[7:5] = 3'h0;
            next_q.core_rst_b  = 1'b0;
          end else if (wdt_to) begin
            next_q.st         = rss_pkg::rss_st_hold;
            next_q.kind       = rss_pkg::rss_k_wdt_run;
            next_q.status     = {3'h0, 2'h1, q.status[2:0]};
            next_q.core_rst_b = 1'b0;
          end else if (sleep_i) begin
            next_q.st                  = rss_pkg::rss_st_sleep;
            next_q.status[`RSS_TO_BIT] = 1'b1;
            next_q.status[`RSS_PD_BIT] = 1'b0;
          end else if (clrwdt_i) begin
            next_q.status[`RSS_TO_BIT] = 1'b1;
            next_q.status[`RSS_PD_BIT] = 1'b1;
          end
        end
        rss_pkg::rss_st_sleep: begin
          if (pin_hold) begin
            next_q.st         = rss_pkg::rss_st_hold;
            next_q.kind       = rss_pkg::rss_k_pin_sleep;
            next_q.status     = {3'h0, 2'h2, q.status[2:0]};
            next_q.core_rst_b = 1'b0;
          end else if (wdt_to) begin
            next_q.st          = rss_pkg::rss_st_run;
            next_q.kind        = rss_pkg::rss_k_wdt_wake;
            next_q.status[4:3] = 2'h0;
            next_q.pc_load     = 1'b1;
            next_q.pc_value    = pc_i + 13'h0001;
          end else if (wake_irq_i) begin
            next_q.st          = rss_pkg::rss_st_run;
            next_q.kind        = rss_pkg::rss_k_irq_wake;
            next_q.status[4:3] = 2'h2;
            next_q.pc_load     = 1'b1;
            next_q.pc_value    = pc_i + 13'h0001;
            next_q.vec_pend    = global_irq_enable_i;
          end
        end
        default: begin
          next_q.st         = rss_pkg::rss_st_hold;
          next_q.core_rst_b = 1'b0;
        end
      endcase
    end

    // true resets: pc to zero, option to reset state, power-up delay and watchdog counts restart
    if (next_q.st == rss_pkg::rss_st_hold) begin
      next_q.pc_load  = 1'b1;
      next_q.pc_value = `RSS_PC_RESET;
      next_q.option   = `RSS_OPTION_RST;
      next_q.powerup_delay_timer_cnt = 12'h000;
    end
    if (!wdt_on || clrwdt_i || sleep_i || next_q.st == rss_pkg::rss_st_hold) begin
      next_q.wdt_cnt = 10'h000;
      if (q.option[`RSS_PSA_BIT]) begin
        next_q.pre = 8'h00;
      end
    end

    // read data stands only in the cycle after the strobe
    if (rd_i) begin
      if (addr_i == `RSS_OFF_STATUS) begin
        next_q.rd_data = q.status;
      end else if (addr_i == `RSS_OFF_OPTION) begin
        next_q.rd_data = q.option;
      end else if (addr_i == `RSS_OFF_POWER_CONTROL_REG) begin
        next_q.rd_data = {6'h00, q.power_control_reg};
      end else begin
        next_q.rd_data = q.tmr0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= Q_RST;
    end else begin
      q <= next_q;
    end
  end

  assign external_reset_pin_o      = q.pin_out;
  assign external_reset_pin_oe_b_o = q.pin_oe_b;
  assign pin_pullup_en_o           = q.pullup_en;
  assign prog_pin_level_o          = q.prog_level;
  assign core_rst_b_o              = q.core_rst_b;
  assign pc_load_o                 = q.pc_load;
  assign pc_value_o                = q.pc_value;
  assign push_o                    = q.push;
  assign reset_kind_o              = q.kind;
  assign status_o                  = q.status;
  assign timer_zero_o              = q.tmr0;
  assign rd_data_o                 = q.rd_data;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_pin_never_driven: assert property (
    external_reset_pin_oe_b_o && !external_reset_pin_o)
    else $error("reset pin driven");

  a_pin_ignored_off: assert property (
    !pin_reset_enable_cfg_i && q.st == rss_pkg::rss_st_run && !por_hold && !bor_hold
    && !wdt_to |=> core_rst_b_o && $stable(q.kind))
    else $error("pin reset while disabled");

  a_delay_holds_core: assert property (
    q.st == rss_pkg::rss_st_delay |-> !core_rst_b_o && q.powerup_delay_timer_cnt <= 12'(`RSS_POWERUP_DELAY_TIMER_TICKS))
    else $error("core released in power-up delay");

  a_release_clean: assert property (
    $rose(core_rst_b_o) |-> !$past(por_hold) && !$past(bor_hold) && !$past(pin_hold))
    else $error("release with hold source active");

  a_pin_run_status: assert property (
    q.st == rss_pkg::rss_st_run && pin_hold && !por_hold && !bor_hold
    |=> q.status[7:5] == 3'h0 && q.status[4:3] == $past(q.status[4:3]) && !core_rst_b_o)
    else $error("pin reset status wrong");

  a_wdt_run_reset: assert property (
    q.st == rss_pkg::rss_st_run && wdt_to && !pin_hold && !por_hold && !bor_hold
    |=> q.status[7:3] == 5'h01 && pc_load_o && pc_value_o == 13'h0000)
    else $error("watchdog reset wrong");

  a_wdt_wake_pc: assert property (
    q.st == rss_pkg::rss_st_sleep && wdt_to && !pin_hold && !por_hold && !bor_hold
    |=> pc_load_o && pc_value_o == $past(pc_i) + 13'h0001 && core_rst_b_o
    && q.status[4:3] == 2'h0)
    else $error("watchdog wake wrong");

  a_irq_vector: assert property (
    q.st == rss_pkg::rss_st_sleep && wake_irq_i && global_irq_enable_i && !wdt_to
    && !pin_hold && !por_hold && !bor_hold
    |=> pc_load_o ##1 pc_load_o && push_o && pc_value_o == 13'h0004)
    else $error("interrupt vector not loaded");

  a_sleep_flags: assert property (
    q.st == rss_pkg::rss_st_run && sleep_i && !wdt_to && !pin_hold && !por_hold
    && !bor_hold |=> q.status[4:3] == 2'h2 && q.st == rss_pkg::rss_st_sleep)
    else $error("sleep flags wrong");

  a_filter_length: assert property (
    q.pin_filt != $past(q.pin_filt) |-> $past(q.filt_cnt) == 5'(FILT_LAST))
    else $error("pin filter too short");

endmodule // rss_sequencer

// ---- rtl/rss_consts.svh ----
/*
  Constants of the reset source sequencer: register offsets, reset values,
  field positions and timing counts.
  Assumes a 10 MHz core clock and a 31 kHz low-frequency oscillator.
*/
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// register offsets on the plain register port
`define RSS_OFF_STATUS 2'h0
`define RSS_OFF_OPTION 2'h1
`define RSS_OFF_POWER_CONTROL_REG   2'h2
`define RSS_OFF_TMR0   2'h3

// field positions
`define RSS_TO_BIT  4
`define RSS_PD_BIT  3
`define RSS_PSA_BIT 3
`define RSS_POR_BIT 1
`define RSS_BOR_BIT 0

// reset values
`define RSS_STATUS_POR 8'h18
`define RSS_OPTION_RST 8'hFF
`define RSS_PC_RESET   13'h0000
`define RSS_PC_VECTOR  13'h0004

// timing
`define RSS_CLK_MHZ      10
`define RSS_LF_HZ        31000
`define RSS_POWERUP_DELAY_TIMER_MS      72
`define RSS_POWERUP_DELAY_TIMER_TICKS   ((`RSS_POWERUP_DELAY_TIMER_MS * `RSS_LF_HZ) / 1000)
`define RSS_WDT_MS       17
`define RSS_WDT_TICKS    ((`RSS_WDT_MS * `RSS_LF_HZ) / 1000)
`define RSS_FILT_NS      2000
`define RSS_FILT_CYC     ((`RSS_FILT_NS * `RSS_CLK_MHZ) / 1000)

`endif

// ---- rtl/rss_pkg.sv ----
/*
  Types of the reset source sequencer: sequencer states, reset kinds and
  the packed state record of the sequencer.
  Assumes rss_consts.svh for all numeric constants.
*/
package rss_pkg;

  typedef enum logic [3:0] {
    rss_st_hold  = 4'h1,
    rss_st_delay = 4'h2,
    rss_st_run   = 4'h4,
    rss_st_sleep = 4'h8
  } rss_state_t;

  typedef enum logic [2:0] {
    rss_k_none      = 3'h0,
    rss_k_por       = 3'h1,
    rss_k_bor       = 3'h2,
    rss_k_wdt_run   = 3'h3,
    rss_k_wdt_wake  = 3'h4,
    rss_k_pin_run   = 3'h5,
    rss_k_pin_sleep = 3'h6,
    rss_k_irq_wake  = 3'h7
  } rss_kind_t;

  typedef struct packed {
    rss_state_t  st;
    rss_kind_t   kind;
    logic [2:0]  pin_sy;
    logic [2:0]  por_sy;
    logic [2:0]  bor_sy;
    logic [2:0]  lf_sy;
    logic        por_lvl;
    logic        bor_lvl;
    logic        lf_lvl;
    logic        pin_filt;
    logic [4:0]  filt_cnt;
    logic [11:0] powerup_delay_timer_cnt;
    logic [9:0]  wdt_cnt;
    logic [7:0]  pre;
    logic [7:0]  tmr0;
    logic [7:0]  status;
    logic [7:0]  option;
    logic [1:0]  power_control_reg;
    logic        core_rst_b;
    logic        pc_load;
    logic        push;
    logic        vec_pend;
    logic [12:0] pc_value;
    logic [7:0]  rd_data;
    logic        pullup_en;
    logic        prog_level;
    logic        pin_out;
    logic        pin_oe_b;
  } rss_q_t;

endpackage

// ---- bench/rss_far_side_model.sv ----
/*
  far side of the reset sequencer: reset pin with its pull-up, supply
  detectors and the slow oscillator.
  assumes the bench commands pin pulls and supply faults.
*/
`timescale 1ns/1ps
module rss_far_side_model #(
  parameter int LF_HALF = 300
) (
  // commands from the bench
  input  wire logic pull_low_i,
  input  wire logic power_fail_i,
  input  wire logic sag_i,
  // device side
  input  wire logic pin_drv_i,
  input  wire logic pin_oe_b_i,
  input  wire logic pullup_en_i,
  output logic      pin_level_o,
  output logic      por_detect_o,
  output logic      bor_detect_o,
  output logic      lf_osc_o
);
  logic last_q = 1'b1;
  // slow oscillator runs free, phase unrelated to the core clock
  initial begin
    lf_osc_o = 1'b0;
    #37;
    forever #(LF_HALF) lf_osc_o = ~lf_osc_o;
  end
  always @(pull_low_i or pullup_en_i) begin
    if (pull_low_i) last_q = 1'b0;
    else if (pullup_en_i) last_q = 1'b1;
  end
  // a loose pin shows the inverse of its last level, never a kind guess
  always_comb begin
    if (!pin_oe_b_i) pin_level_o = pin_drv_i;
    else if (pull_low_i) pin_level_o = 1'b0;
    else if (pullup_en_i) pin_level_o = 1'b1;
    else pin_level_o = ~last_q;
  end
  assign por_detect_o = power_fail_i;
  assign bor_detect_o = sag_i;
endmodule // rss_far_side_model

// ---- bench/reset_source_sequencer_tb_top.sv ----
/*
  bench of the reset sequencer: power-up, register port, pin filter,
  sleep and wake, watchdog and brown-out sequences.
  assumes the far side model and a 10 MHz clock.
*/
`timescale 1ns/1ps
`include "rss_consts.svh"
module reset_source_sequencer_tb_top;
  // slow oscillator sped up to one tick per 6 core cycles
  localparam int DLY = `RSS_POWERUP_DELAY_TIMER_TICKS * 6;
  localparam int WDT = `RSS_WDT_TICKS * 6;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        pull_low = 1'b0;
  logic        power_fail = 1'b1;
  logic        sag = 1'b0;
  logic        pin_reset_enable_cfg_i = 1'b1;
  logic        powerup_delay_enable_cfg_b_i = 1'b0;
  logic        watchdog_enable_cfg_i = 1'b0;
  logic [1:0]  brownout_enable_cfg_i = 2'h0;
  logic        sleep_i = 1'b0;
  logic        clrwdt_i = 1'b0;
  logic        wake_irq_i = 1'b0;
  logic        global_irq_enable_i = 1'b0;
  logic [12:0] pc_i = 13'h0000;
  logic [1:0]  addr_i = 2'h0;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  wire logic external_reset_pin_i, external_reset_pin_o, external_reset_pin_oe_b_o;
  wire logic pin_pullup_en_o, prog_pin_level_o, por_detect_i, bor_detect_i, lf_osc_i;
  wire logic core_rst_b_o, pc_load_o, push_o;
  wire logic [12:0] pc_value_o;
  wire logic [2:0]  reset_kind_o;
  wire logic [7:0]  status_o, timer_zero_o, rd_data_o;
  int          errors = 0;
  int          comparisons = 0;
  logic [31:0] rng = 32'h0000_E3F0;
  logic [7:0]  v;
  logic [7:0]  t;
  logic [12:0] pc;

  always #50 clk_i = ~clk_i;

  rss_sequencer dut (
    .clk_i, .rst_b_i, .external_reset_pin_i, .external_reset_pin_o,
    .external_reset_pin_oe_b_o, .pin_pullup_en_o, .prog_pin_level_o,
    .por_detect_i, .bor_detect_i, .lf_osc_i, .pin_reset_enable_cfg_i,
    .powerup_delay_enable_cfg_b_i, .watchdog_enable_cfg_i, .brownout_enable_cfg_i,
    .sleep_i, .clrwdt_i, .wake_irq_i, .global_irq_enable_i, .pc_i, .core_rst_b_o,
    .pc_load_o, .pc_value_o, .push_o, .reset_kind_o, .status_o, .timer_zero_o,
    .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o
  );
  rss_far_side_model #(.LF_HALF(300)) far (
    .pull_low_i(pull_low), .power_fail_i(power_fail), .sag_i(sag),
    .pin_drv_i(external_reset_pin_o), .pin_oe_b_i(external_reset_pin_oe_b_o),
    .pullup_en_i(pin_pullup_en_o), .pin_level_o(external_reset_pin_i),
    .por_detect_o(por_detect_i), .bor_detect_o(bor_detect_i), .lf_osc_o(lf_osc_i)
  );

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [12:0] wake_pc(logic [12:0] p);
    return p + 13'h0001;
  endfunction
  function automatic logic [7:0] st_wr(logic [7:0] s, logic [7:0] w);
    return {w[7:5], s[4:3], w[2:0]};
  endfunction
  function automatic logic probe(int w);
    return (w == 0) ? core_rst_b_o : pc_load_o;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL %0t %s", $time, msg);
      errors++;
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_for(input int w, input logic x, input int bound);
    int n;
    n = 0;
    while (probe(w) !== x && n < bound) begin
      tick(1);
      n++;
    end
    if (probe(w) !== x) begin
      $display("FAIL %0t wait ran out", $time);
      errors++;
      test_done();
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk_i) addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i) wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i) addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i) rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  task automatic nap();
    @(posedge clk_i) sleep_i <= 1'b1;
    @(posedge clk_i) sleep_i <= 1'b0;
    #1;
  endtask
  task automatic yank(int n);
    @(posedge clk_i) pull_low <= 1'b1;
    tick(n);
  endtask

  initial begin
    tick(5);
    check(status_o, `RSS_STATUS_POR, "status in reset");
    check({external_reset_pin_oe_b_o, external_reset_pin_o}, 2'b10, "pin driven");
    tick(4);
    @(posedge clk_i) rst_b_i <= 1'b1;
    tick(50);
    check(core_rst_b_o, 1'b0, "run under power-on");
    @(posedge clk_i) power_fail <= 1'b0;
    tick(DLY - 600);
    check(core_rst_b_o, 1'b0, "delay short");
    wait_for(0, 1'b1, 1200);
    check(reset_kind_o, 3'h1, "kind power-on");
    check(pin_pullup_en_o, 1'b1, "pull-up off");
    rd(`RSS_OFF_POWER_CONTROL_REG, v);
    check(v, 8'h00, "flags power-on");
    rd(`RSS_OFF_OPTION, v);
    check(v, `RSS_OPTION_RST, "option reset");
    wr(`RSS_OFF_POWER_CONTROL_REG, 8'hFF);
    rd(`RSS_OFF_POWER_CONTROL_REG, v);
    check(v, 8'h03, "flag write");
    repeat (6) begin
      t = 8'(xs());
      wr(`RSS_OFF_OPTION, t);
      rd(`RSS_OFF_OPTION, v);
      check(v, t, "option readback");
    end
    // 1:2 with the prescaler on timer zero, 1:1 when it goes to the watchdog
    for (int p = 0; p < 2; p++) begin
      wr(`RSS_OFF_OPTION, (p == 1) ? 8'h08 : 8'h00);
      tick(2);
      t = timer_zero_o;
      tick(20);
      check(timer_zero_o, 8'(t + ((p == 1) ? 20 : 10)), "timer rate");
    end
    rd(`RSS_OFF_STATUS, t);
    wr(`RSS_OFF_STATUS, 8'hA5);
    rd(`RSS_OFF_STATUS, v);
    check(v, st_wr(t, 8'hA5), "status write");
    yank(12);
    @(posedge clk_i) pull_low <= 1'b0;
    tick(40);
    check(core_rst_b_o, 1'b1, "glitch reset");
    yank(5);
    wait_for(0, 1'b0, 40);
    check(reset_kind_o, 3'h5, "kind pin run");
    check(status_o, {3'h0, v[4:0]}, "status pin run");
    check({pc_load_o, pc_value_o}, {1'b1, `RSS_PC_RESET}, "pc reset");
    rd(`RSS_OFF_POWER_CONTROL_REG, t);
    check(t, 8'h03, "flags pin run");
    @(posedge clk_i) pull_low <= 1'b0;
    wait_for(0, 1'b1, 40);
    @(posedge clk_i) pin_reset_enable_cfg_i <= 1'b0;
    yank(40);
    check(pin_pullup_en_o, 1'b0, "pull-up on");
    check(prog_pin_level_o, 1'b0, "prog level");
    check(core_rst_b_o, 1'b1, "pin not ignored");
    @(posedge clk_i) pull_low <= 1'b0;
    tick(40);
    @(posedge clk_i) pin_reset_enable_cfg_i <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      nap();
      check(status_o[4:3], 2'b10, "flags sleep");
      pc = (g == 1) ? 13'h1FFF : 13'(xs());
      @(posedge clk_i) wake_irq_i <= 1'b1;
      global_irq_enable_i <= g[0];
      pc_i <= pc;
      @(posedge clk_i) wake_irq_i <= 1'b0;
      #1;
      check({pc_load_o, pc_value_o}, {1'b1, wake_pc(pc)}, "wake pc");
      check(status_o[4:3], 2'b10, "flags irq wake");
      tick(1);
      check(push_o, g[0], "push");
      if (g == 1) check(pc_value_o, `RSS_PC_VECTOR, "vector");
    end
    nap();
    yank(5);
    wait_for(0, 1'b0, 40);
    check(reset_kind_o, 3'h6, "kind pin sleep");
    check(status_o[7:3], 5'b00010, "status pin sleep");
    @(posedge clk_i) pull_low <= 1'b0;
    wait_for(0, 1'b1, 40);
    wr(`RSS_OFF_OPTION, 8'h00);
    @(posedge clk_i) watchdog_enable_cfg_i <= 1'b1;
    @(posedge clk_i) clrwdt_i <= 1'b1;
    @(posedge clk_i) clrwdt_i <= 1'b0;
    #1;
    check(status_o[4:3], 2'b11, "flags clear");
    tick(WDT - 300);
    check(core_rst_b_o, 1'b1, "watchdog early");
    wait_for(0, 1'b0, 700);
    check(reset_kind_o, 3'h3, "kind watchdog");
    check(status_o[7:3], 5'b00001, "status watchdog");
    wait_for(0, 1'b1, 10);
    rd(`RSS_OFF_OPTION, v);
    check(v, `RSS_OPTION_RST, "option after watchdog");
    wr(`RSS_OFF_OPTION, 8'h00);
    pc = 13'(xs());
    @(posedge clk_i) pc_i <= pc;
    nap();
    wait_for(1, 1'b1, WDT + 700);
    check(pc_value_o, wake_pc(pc), "watchdog wake pc");
    check(reset_kind_o, 3'h4, "kind wake");
    check(status_o[4:3], 2'b00, "flags wake");
    check(core_rst_b_o, 1'b1, "wake reset core");
    rd(`RSS_OFF_OPTION, v);
    check(v, 8'h00, "option after wake");
    @(posedge clk_i) watchdog_enable_cfg_i <= 1'b0;
    @(posedge clk_i) brownout_enable_cfg_i <= 2'h3;
    powerup_delay_enable_cfg_b_i <= 1'b0;
    @(posedge clk_i) sag <= 1'b1;
    wait_for(0, 1'b0, 20);
    check(reset_kind_o, 3'h2, "kind brown-out");
    tick(100);
    @(posedge clk_i) sag <= 1'b0;
    tick(DLY - 600);
    check(core_rst_b_o, 1'b0, "brown-out delay short");
    wait_for(0, 1'b1, 1200);
    check(status_o[7:3], 5'b00011, "status brown-out");
    rd(`RSS_OFF_POWER_CONTROL_REG, v);
    check(v, 8'h02, "flags brown-out");
    // off in both settings: 01 always, 10 only while asleep
    for (int c = 1; c < 3; c++) begin
      @(posedge clk_i) brownout_enable_cfg_i <= 2'(c);
      if (c == 2) nap();
      @(posedge clk_i) sag <= 1'b1;
      tick(50);
      check(core_rst_b_o, 1'b1, "brown-out not ignored");
      @(posedge clk_i) sag <= 1'b0;
      // let the detector level settle before the enable field changes again
      tick(10);
    end
    @(posedge clk_i) brownout_enable_cfg_i <= 2'h3;
    powerup_delay_enable_cfg_b_i <= 1'b1;
    @(posedge clk_i) sag <= 1'b1;
    wait_for(0, 1'b0, 20);
    @(posedge clk_i) sag <= 1'b0;
    wait_for(0, 1'b1, 50);
    test_done();
  end
endmodule // reset_source_sequencer_tb_top
